// ### shared/burst_sram_pkg.sv
package burst_sram_pkg;
  // ---------------------------------------------------------------
  // organisation
  // ---------------------------------------------------------------
  localparam int WIDE_DATA = 36;
  localparam int WIDE_ADDR = 19;
  localparam int WIDE_LANES = 4;
  localparam int NARROW_DATA = 18;
  localparam int NARROW_ADDR = 20;
  localparam int NARROW_LANES = 2;
  localparam int SEED_BITS = 2;
  // ---------------------------------------------------------------
  // burst order encodings
  // ---------------------------------------------------------------
  localparam logic BURST_LINEAR = 1'b1;
  localparam logic BURST_INTERLEAVED = 1'b0;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MAX_FREQ_MHZ = 133;
  localparam int READ_LATENCY_CYCLES = 0;
  localparam int WRITE_DATA_DELAY = 1;
  // ---------------------------------------------------------------
  // control carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic selectLowA;
    logic selectHigh;
    logic selectLowB;
    logic writeN;
    logic advanceOrLoad;
  } ctrl_t;
endpackage

// ### hdl/ecc_codec.sv
// ---------------------------------------------------------------
// single-error-correct hamming codec per byte lane
// ---------------------------------------------------------------
module ecc_codec #(
  parameter int DW = 9,
  parameter int PW = 4
) (
  dataIn,
  checkIn,
  dataOut,
  checkOut
);
  input wire logic [DW-1:0] dataIn;
  input wire logic [PW-1:0] checkIn;
  output logic [DW-1:0] dataOut;
  output logic [PW-1:0] checkOut;

  // position of data bit i in the hamming word (skips powers of two)
  function automatic int posOf(input int i);
    int p;
    int n;
    p = 0;
    n = -1;
    while (n < i)
    begin
      p = p + 1;
      if ((p & (p - 1)) != 0)
        n = n + 1;
    end
    return p;
  endfunction

  function automatic logic [PW-1:0] parity(input logic [DW-1:0] d);
    logic [PW-1:0] c;
    c = '0;
    for (int i = 0; i < DW; i++)
      if (d[i])
        c = c ^ PW'(posOf(i));
    return c;
  endfunction

  logic [PW-1:0] syndrome;

  always_comb
  begin
    checkOut = parity(dataIn);
    syndrome = parity(dataIn) ^ checkIn;
    dataOut = dataIn;
    for (int i = 0; i < DW; i++)
      if (syndrome == PW'(posOf(i)))
        dataOut[i] = ~dataIn[i];
  end
endmodule

// ### hdl/flowthrough_burst_sram_core.sv
// Overview of operation
// - all synchronous inputs registered on rising clock
// - clock hold high freezes all state
// - reads and writes back to back, no gaps
// - read data flows from array, unregistered
// - 512K x 36 or 1M x 18 array
// - write only when enabled, per byte lane
// - selected only when all three selects active
// - async output enable gates data drivers
// - outputs off during write data phase
// - output buffers controlled internally
// - burst order linear or interleaved
// - low power when sleeping or deselected
// - on-chip ecc corrects soft errors
// - zero wait states every enabled cycle
// - advance increments counter, load takes address
// - two low address bits seed counter
// - sleep input preserves data, defaults low
module flowthrough_burst_sram_core
  import burst_sram_pkg::*;
#(
  parameter int DW = burst_sram_pkg::WIDE_DATA,
  parameter int AW = burst_sram_pkg::WIDE_ADDR,
  parameter int LANES = burst_sram_pkg::WIDE_LANES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clock_hold_n,
  input wire logic [AW-1:0] addr,
  input wire burst_sram_pkg::ctrl_t ctrl,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic outEnableN,
  input wire logic sleep_request,
  input wire logic zero_turnaround_mode,
  input wire logic [DW-1:0] dataIn,
  output logic [DW-1:0] dataOut,
  output logic dataOutEnN,
  output logic lowPower
);
  import burst_sram_pkg::*;

  localparam int LW = DW / LANES;
  localparam int PW = 4;
  localparam int DEPTH = 1 << AW;

  // ---------------------------------------------------------------
  // storage with per-lane check bits
  // ---------------------------------------------------------------
  logic [DW-1:0] memData [DEPTH];
  logic [LANES*PW-1:0] memCheck [DEPTH];

  // ---------------------------------------------------------------
  // access state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } acc_t;

  acc_t state_q, state_d;
  logic [AW-1:0] base_q, base_d;
  logic [SEED_BITS-1:0] seed_q, seed_d;
  logic [SEED_BITS-1:0] count_q, count_d;
  logic [LANES-1:0] lanes_q, lanes_d;
  logic wrPend_q, wrPend_d;
  logic order_q, order_d;

  logic selected;
  logic enabled;
  logic [SEED_BITS-1:0] burstIdx;
  logic [AW-1:0] curAddr;

  assign enabled = ~clock_hold_n & ~rst;
  assign selected = ~ctrl.selectLowA & ctrl.selectHigh & ~ctrl.selectLowB;

  always_comb
  begin
    if (order_q == BURST_LINEAR)
      burstIdx = seed_q + count_q;
    else
      burstIdx = seed_q ^ count_q;
    curAddr = {base_q[AW-1:SEED_BITS], burstIdx};
  end

  always_comb
  begin
    state_d = state_q;
    base_d = base_q;
    seed_d = seed_q;
    count_d = count_q;
    lanes_d = lanes_q;
    order_d = order_q;
    wrPend_d = 1'b0;
    if (enabled)
    begin
      wrPend_d = (state_q == ST_WRITE);
      if (!ctrl.advanceOrLoad)
      begin
        order_d = zero_turnaround_mode;
        if (selected)
        begin
          base_d = addr;
          seed_d = addr[SEED_BITS-1:0];
          count_d = '0;
          lanes_d = ~byte_lane_write_n;
          state_d = ctrl.writeN ? ST_READ : ST_WRITE;
        end
        else
          state_d = ST_IDLE;
      end
      else if (state_q != ST_IDLE)
      begin
        count_d = count_q + 1'b1;
        lanes_d = ~byte_lane_write_n;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      base_q <= '0;
      seed_q <= '0;
      count_q <= '0;
      lanes_q <= '0;
      order_q <= BURST_LINEAR;
      wrPend_q <= 1'b0;
    end
    else if (!clock_hold_n)
    begin
      state_q <= state_d;
      base_q <= base_d;
      seed_q <= seed_d;
      count_q <= count_d;
      lanes_q <= lanes_d;
      order_q <= order_d;
      wrPend_q <= wrPend_d;
    end
  end

  // ---------------------------------------------------------------
  // ecc encode on write, correct on read
  // ---------------------------------------------------------------
  logic [DW-1:0] rdRaw, rdFixed;
  logic [LANES*PW-1:0] rdCheck, wrCheck;

  assign rdRaw = memData[curAddr];
  assign rdCheck = memCheck[curAddr];

  generate
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
      ecc_codec #(.DW(LW), .PW(PW)) u_rd (
        .dataIn(rdRaw[g*LW +: LW]),
        .checkIn(rdCheck[g*PW +: PW]),
        .dataOut(rdFixed[g*LW +: LW]),
        .checkOut()
      );
      ecc_codec #(.DW(LW), .PW(PW)) u_wr (
        .dataIn(dataIn[g*LW +: LW]),
        .checkIn('0),
        .dataOut(),
        .checkOut(wrCheck[g*PW +: PW])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (!rst && !clock_hold_n && state_q == ST_WRITE)
      for (int g = 0; g < LANES; g++)
        if (lanes_q[g])
        begin
          memData[curAddr][g*LW +: LW] <= dataIn[g*LW +: LW];
          memCheck[curAddr][g*PW +: PW] <= wrCheck[g*PW +: PW];
        end
  end

  // ---------------------------------------------------------------
  // output path
  // ---------------------------------------------------------------
  assign dataOut = (state_q == ST_READ) ? rdFixed : '0;
  assign dataOutEnN = outEnableN | (state_q != ST_READ);
  assign lowPower = sleep_request | (state_q == ST_IDLE);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_loadWrite;
    !clock_hold_n && !ctrl.advanceOrLoad && selected && !ctrl.writeN;
  endsequence

  sequence s_loadRead;
    !clock_hold_n && !ctrl.advanceOrLoad && selected && ctrl.writeN;
  endsequence

  a_write_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
    s_loadWrite |=> dataOutEnN)
    else $error("outputs driven in write data phase");

  a_read_drives: assert property (@(posedge ref_clk) disable iff (rst)
    s_loadRead |=> (state_q == ST_READ))
    else $error("read not started next cycle");

  a_oe_gates: assert property (@(posedge ref_clk) disable iff (rst)
    outEnableN |-> dataOutEnN)
    else $error("output enable ignored");

  a_hold_freezes: assert property (@(posedge ref_clk) disable iff (rst)
    clock_hold_n |=> $stable(state_q) && $stable(count_q))
    else $error("state moved while clock held");

  a_deselect_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (!clock_hold_n && !ctrl.advanceOrLoad && !selected) |=> lowPower && dataOutEnN)
    else $error("deselect not honoured");

  a_burst_step: assert property (@(posedge ref_clk) disable iff (rst)
    (!clock_hold_n && ctrl.advanceOrLoad && state_q != ST_IDLE)
      |=> count_q == $past(count_q) + 2'd1)
    else $error("burst counter did not advance");

  a_load_seed: assert property (@(posedge ref_clk) disable iff (rst)
    (!clock_hold_n && !ctrl.advanceOrLoad && selected)
      |=> count_q == '0 && seed_q == $past(addr[SEED_BITS-1:0]))
    else $error("burst seed not loaded");

  a_sleep_power: assert property (@(posedge ref_clk) disable iff (rst)
    sleep_request |-> lowPower)
    else $error("sleep not reflected");

  a_write_pend: assert property (@(posedge ref_clk) disable iff (rst)
    (!clock_hold_n && state_q == ST_WRITE) |=> wrPend_q)
    else $error("write data phase not tracked");

  a_read_oe_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == ST_READ && !outEnableN) |-> !dataOutEnN)
    else $error("read data not driven");

  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == ST_IDLE) |-> dataOutEnN && dataOut == '0)
    else $error("idle device drives data");

  a_load_order: assert property (@(posedge ref_clk) disable iff (rst)
    (!clock_hold_n && !ctrl.advanceOrLoad) |=> order_q == $past(zero_turnaround_mode))
    else $error("burst order not captured");

  a_load_base: assert property (@(posedge ref_clk) disable iff (rst)
    (!clock_hold_n && !ctrl.advanceOrLoad && selected) |=> base_q == $past(addr))
    else $error("address not captured");

  a_lane_capture: assert property (@(posedge ref_clk) disable iff (rst)
    (!clock_hold_n && !ctrl.advanceOrLoad && selected)
      |=> lanes_q == ~$past(byte_lane_write_n))
    else $error("byte lanes not captured on load");

  a_lane_advance: assert property (@(posedge ref_clk) disable iff (rst)
    (!clock_hold_n && ctrl.advanceOrLoad && state_q != ST_IDLE)
      |=> lanes_q == ~$past(byte_lane_write_n))
    else $error("byte lanes not captured on advance");
endmodule

// ### testbench/sram_ctrl_model.sv
// ---------------------------------------------------------------
// memory controller issuing one access per enabled cycle
// ---------------------------------------------------------------
module sram_ctrl_model
  import burst_sram_pkg::*;
(
  input wire logic ref_clk,
  output logic clock_hold_n,
  output logic [WIDE_ADDR-1:0] addr,
  output burst_sram_pkg::ctrl_t ctrl,
  output logic [WIDE_LANES-1:0] byte_lane_write_n,
  output logic zero_turnaround_mode,
  output logic [WIDE_DATA-1:0] dataIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wrNow = 1'b0;
  logic [WIDE_DATA-1:0] wdNow = '0;
  initial
  begin
    clock_hold_n = 1'b1;
    addr = '0;
    ctrl = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    byte_lane_write_n = '1;
    zero_turnaround_mode = BURST_LINEAR;
    dataIn = '0;
  end
  // write data one enabled cycle after its address, inverted otherwise
  always @(posedge ref_clk)
  begin
    if (!clock_hold_n)
      dataIn <= wrNow ? wdNow : ~dataIn;
  end
  task automatic op(input logic wr, input logic adv, input logic [2:0] sel,
    input logic [18:0] a, input logic [3:0] ln, input logic [35:0] wd, input logic lin);
    @(posedge ref_clk);
    clock_hold_n <= 1'b0;
    ctrl <= '{sel[2], sel[1], sel[0], ~wr, adv};
    addr <= a;
    byte_lane_write_n <= ln;
    zero_turnaround_mode <= lin;
    wrNow <= wr;
    wdNow <= wd;
  endtask
  task automatic stall();
    @(posedge ref_clk);
    clock_hold_n <= 1'b1;
  endtask
endmodule

// ### testbench/flowthrough_burst_sram_core_test.sv
module flowthrough_burst_sram_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  import burst_sram_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic outEnableN = 1'b0;
  logic sleep_request = 1'b0;
  logic clock_hold_n;
  logic [WIDE_ADDR-1:0] addr;
  ctrl_t ctrl;
  logic [WIDE_LANES-1:0] byte_lane_write_n;
  logic zero_turnaround_mode;
  logic [WIDE_DATA-1:0] dataIn, dataOut, chkVal_d, chkVal_q;
  logic dataOutEnN, lowPower;
  logic [1:0] chkKind_d = 2'h0;
  logic [1:0] chkKind_q;
  logic [2:0] badSel [3] = '{3'b110, 3'b000, 3'b011};
  logic [35:0] mem [int];
  int err_total = 0;
  int n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  flowthrough_burst_sram_core dut (.ref_clk(ref_clk), .rst(rst), .clock_hold_n(clock_hold_n),
    .addr(addr), .ctrl(ctrl), .byte_lane_write_n(byte_lane_write_n),
    .outEnableN(outEnableN), .sleep_request(sleep_request),
    .zero_turnaround_mode(zero_turnaround_mode), .dataIn(dataIn), .dataOut(dataOut),
    .dataOutEnN(dataOutEnN), .lowPower(lowPower));
  sram_ctrl_model ctl (.ref_clk(ref_clk), .clock_hold_n(clock_hold_n), .addr(addr),
    .ctrl(ctrl), .byte_lane_write_n(byte_lane_write_n),
    .zero_turnaround_mode(zero_turnaround_mode), .dataIn(dataIn));
  // ---------------------------------------------------------------
  // expectation pipeline, advanced on enabled edges only
  // ---------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
      chkKind_q <= 2'h0;
    else if (!clock_hold_n)
    begin
      chkKind_q <= chkKind_d;
      chkVal_q <= chkVal_d;
    end
  end
  always @(negedge ref_clk)
  begin
    if (!rst && chkKind_q == 2'h1)
    begin
      cmp("readData", chkVal_q, dataOut);
      cmp("readEnable", 36'(outEnableN), 36'(dataOutEnN));
      cmp("readPower", 36'(sleep_request), 36'(lowPower));
    end
    else if (!rst && chkKind_q == 2'h2)
      cmp("writeTristate", 36'h1, 36'(dataOutEnN));
    else if (!rst && chkKind_q == 2'h3)
    begin
      cmp("deselPower", 36'h1, 36'(lowPower));
      cmp("deselTristate", 36'h1, 36'(dataOutEnN));
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic cmp(input string nm, input logic [35:0] e, input logic [35:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic wr, input logic adv, input logic [18:0] pinA,
    input logic [18:0] memA, input logic [3:0] ln, input logic [35:0] wd, input logic lin);
    ctl.op(wr, adv, 3'b010, pinA, ln, wd, lin);
    chkKind_d <= wr ? 2'h2 : 2'h1;
    if (wr)
      for (int i = 0; i < 4; i++)
        if (!ln[i])
          mem[memA][9*i+:9] = wd[9*i+:9];
    if (!wr)
      chkVal_d <= mem[memA];
  endtask
  task automatic burst(input logic wr, input logic [18:0] a, input logic lin,
    input logic [35:0] base);
    for (int k = 0; k < 4; k++)
      acc(wr, k != 0, k == 0 ? a : ~a, lin ? {a[18:2], a[1:0] + 2'(k)} :
        {a[18:2], a[1:0] ^ 2'(k)}, 4'h0, base + 36'(k), lin);
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    report_and_stop();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    cmp("rstPower", 36'h1, 36'(lowPower));
    cmp("rstEnable", 36'h1, 36'(dataOutEnN));
    burst(1'b1, 19'h00106, BURST_LINEAR, 36'h123456780);
    burst(1'b0, 19'h00105, BURST_INTERLEAVED, 36'h0);
    acc(1'b1, 1'b0, 19'h00200, 19'h00200, 4'h0, 36'hfedcba987, BURST_LINEAR);
    acc(1'b0, 1'b0, 19'h00104, 19'h00104, 4'hf, 36'h0, BURST_LINEAR);
    acc(1'b1, 1'b0, 19'h00200, 19'h00200, 4'b1010, 36'h0aaaaaaaa, BURST_LINEAR);
    acc(1'b0, 1'b0, 19'h00107, 19'h00107, 4'hf, 36'h0, BURST_LINEAR);
    acc(1'b0, 1'b0, 19'h00200, 19'h00200, 4'hf, 36'h0, BURST_LINEAR);
    acc(1'b0, 1'b0, 19'h00106, 19'h00106, 4'hf, 36'h0, BURST_LINEAR);
    ctl.stall();
    outEnableN <= 1'b1;
    ctl.stall();
    outEnableN <= 1'b0;
    acc(1'b0, 1'b1, 19'h7fef9, 19'h00107, 4'hf, 36'h0, BURST_LINEAR);
    for (int s = 0; s < 3; s++)
    begin
      ctl.op(1'b1, 1'b0, badSel[s], 19'h00106, 4'h0, 36'h0, BURST_LINEAR);
      chkKind_d <= 2'h3;
    end
    acc(1'b0, 1'b0, 19'h00106, 19'h00106, 4'hf, 36'h0, BURST_LINEAR);
    ctl.stall();
    sleep_request <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp("sleepPower", 36'h1, 36'(lowPower));
    @(posedge ref_clk);
    sleep_request <= 1'b0;
    acc(1'b0, 1'b0, 19'h00200, 19'h00200, 4'hf, 36'h0, BURST_LINEAR);
    ctl.stall();
    repeat (2) @(negedge ref_clk);
    report_and_stop();
  end
endmodule
